// *** src/vtp_map.vh ***
// register map, field positions and colour constants of the video test pattern block
`ifndef VTP_MAP_VH
`define VTP_MAP_VH
// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define VTP_IDX_TXPWR    8'h63
`define VTP_IDX_CTL      8'h64
`define VTP_IDX_CFG      8'h65
`define VTP_IDX_RED      8'h70
`define VTP_IDX_GRN      8'h71
`define VTP_IDX_BLU      8'h72
`define VTP_IDX_FTIME    8'h73
`define VTP_IDX_STAT     8'h74
// ----------------------------------------
// reset values
// ----------------------------------------
`define VTP_RST_TXPWR    8'h00
`define VTP_RST_CTL      8'h10
`define VTP_RST_CFG      8'h00
`define VTP_RST_CUST     8'h00
`define VTP_RST_FTIME    8'h01
// ----------------------------------------
// field positions
// ----------------------------------------
`define VTP_TX_PWDN      0
`define VTP_CTL_EN       0
`define VTP_CTL_VREV     1
`define VTP_CTL_BARS     2
`define VTP_CTL_COMP     3
`define VTP_CTL_SEL      7:4
`define VTP_CFG_ASCRL    0
`define VTP_CFG_INV      1
`define VTP_CFG_18B      4
`define VTP_CFG_MASK     8'h13
// ----------------------------------------
// pattern codes
// ----------------------------------------
`define VTP_SEL_FIRST    4'h1
`define VTP_SEL_LAST     4'hE
`define VTP_SEL_CUSTOM   4'hE
// ----------------------------------------
// colours and pixel constants
// ----------------------------------------
`define VTP_WHITE        24'hFFFFFF
`define VTP_BLACK        24'h000000
`define VTP_RED          24'hFF0000
`define VTP_GREEN        24'h00FF00
`define VTP_BLUE         24'h0000FF
`define VTP_CYAN         24'h00FFFF
`define VTP_MAGENTA      24'hFF00FF
`define VTP_YELLOW       24'hFFFF00
`define VTP_MASK18       24'hFCFCFC
`define VTP_LEVELS       16'h0100
`define VTP_RESP_OKAY    2'h0
`define VTP_RESP_SLVERR  2'h2
`endif

// *** src/vtp_top.v ***
// video test pattern control with register slave, pixel generator and output fifo
// ----------------------------------------
`timescale 1ns/1ps
`include "vtp_map.vh"
// ----------------------------------------
// output fifo
// ----------------------------------------
module vtp_fifo #(
   parameter W  = 24,
   parameter D  = 8,
   parameter AW = 3
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   output wire          out_valid,
   input  wire          out_ready,
   output wire [W-1:0]  out_data,
   output wire [AW:0]   level
);
   reg [W-1:0]  mem_q [0:D-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0]   cnt_q;
   wire         push;
   wire         pop;
   assign in_ready  = (cnt_q != D[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem_q[rd_q];
   assign level     = cnt_q;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   // storage is never cleared: nothing reads it while the fifo is empty
   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q        <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            mem_q[wr_q] <= in_data;
         end
         if (pop) begin
            rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
// ----------------------------------------
// top level
// ----------------------------------------
module vtp_top #(
   parameter H_ACTIVE = 16'd1920,
   parameter V_ACTIVE = 16'd1080,
   parameter FIFO_D   = 8,
   parameter FIFO_AW  = 3
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        vid_valid,
   output wire        vid_ready,
   input  wire [23:0] vid_data,
   output wire        pix_valid,
   input  wire        pix_ready,
   output wire [23:0] pix_data,
   output wire        loopthrough_tx_powerdown
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0]  txpwr_q, ctl_q, cfg_q, red_q, grn_q, blu_q, ftime_q;
   reg [7:0]  aw_idx_q, wdat_q, rd_val;
   reg        aw_have_q, w_have_q, wlane_q, rd_hit, wr_hit;
   wire       wr_fire;
   wire [7:0] ar_idx;
   assign loopthrough_tx_powerdown = txpwr_q[`VTP_TX_PWDN];
   // write address and data accepted in either order, one write at a time
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
   assign wr_fire       = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign ar_idx        = s_axi_araddr[9:2];
   always @* begin
      wr_hit = ((aw_idx_q >= `VTP_IDX_TXPWR) && (aw_idx_q <= `VTP_IDX_CFG))
               || ((aw_idx_q >= `VTP_IDX_RED) && (aw_idx_q <= `VTP_IDX_STAT));
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         aw_idx_q     <= 8'h00;
         wdat_q       <= 8'h00;
         wlane_q      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `VTP_RESP_OKAY;
         txpwr_q      <= `VTP_RST_TXPWR;
         ctl_q        <= `VTP_RST_CTL;
         cfg_q        <= `VTP_RST_CFG;
         red_q        <= `VTP_RST_CUST;
         grn_q        <= `VTP_RST_CUST;
         blu_q        <= `VTP_RST_CUST;
         ftime_q      <= `VTP_RST_FTIME;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr[9:2];
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_q <= 1'b1;
            wdat_q   <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `VTP_RESP_OKAY : `VTP_RESP_SLVERR;
            if (wlane_q) begin
               case (aw_idx_q)
                  `VTP_IDX_TXPWR: txpwr_q <= wdat_q;
                  `VTP_IDX_CTL:   ctl_q   <= wdat_q;
                  `VTP_IDX_CFG:   cfg_q   <= wdat_q & `VTP_CFG_MASK;
                  `VTP_IDX_RED:   red_q   <= wdat_q;
                  `VTP_IDX_GRN:   grn_q   <= wdat_q;
                  `VTP_IDX_BLU:   blu_q   <= wdat_q;
                  `VTP_IDX_FTIME: ftime_q <= wdat_q;
                  default: ;
               endcase
            end
         end
      end
   end
   // ----------------------------------------
   // read side
   // ----------------------------------------
   reg [3:0]          scroll_sel_q;
   wire [3:0]         act_sel;
   wire [FIFO_AW:0]   fifo_level;
   always @* begin
      rd_hit = 1'b1;
      rd_val = 8'h00;
      case (ar_idx)
         `VTP_IDX_TXPWR: rd_val = txpwr_q;
         `VTP_IDX_CTL:   rd_val = ctl_q;
         `VTP_IDX_CFG:   rd_val = cfg_q;
         `VTP_IDX_RED:   rd_val = red_q;
         `VTP_IDX_GRN:   rd_val = grn_q;
         `VTP_IDX_BLU:   rd_val = blu_q;
         `VTP_IDX_FTIME: rd_val = ftime_q;
         `VTP_IDX_STAT:  rd_val = {3'h0, ctl_q[`VTP_CTL_EN], act_sel};
         default:        rd_hit = 1'b0;
      endcase
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `VTP_RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, rd_val};
         s_axi_rresp  <= rd_hit ? `VTP_RESP_OKAY : `VTP_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // ----------------------------------------
   // raster position and ramp levels
   // ----------------------------------------
   reg [15:0] x_q, y_q, hacc_q;
   reg [7:0]  hlvl_q, vlvl_q, fcnt_q;
   reg [16:0] hsum;
   reg [23:0] vnext;
   wire       take, eol, eof;
   assign take = vid_valid & vid_ready;
   assign eol  = (x_q == H_ACTIVE - 16'd1);
   assign eof  = eol & (y_q == V_ACTIVE - 16'd1);
   // accumulate 256 per pixel, step once per width: 256*x/width without a divider;
   // lines come slowly, so a constant divide also serves frames under 256 lines
   always @* begin
      hsum  = {1'b0, hacc_q} + {1'b0, `VTP_LEVELS};
      vnext = (({8'h00, y_q} + 24'h000001) * {8'h00, `VTP_LEVELS}) / {8'h00, V_ACTIVE};
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         x_q    <= 16'h0000;
         y_q    <= 16'h0000;
         hacc_q <= 16'h0000;
         hlvl_q <= 8'h00;
         vlvl_q <= 8'h00;
      end else if (take) begin
         if (eol) begin
            x_q    <= 16'h0000;
            hacc_q <= 16'h0000;
            hlvl_q <= 8'h00;
            if (eof) begin
               y_q    <= 16'h0000;
               vlvl_q <= 8'h00;
            end else begin
               y_q    <= y_q + 16'd1;
               vlvl_q <= vnext[7:0];
            end
         end else begin
            x_q <= x_q + 16'd1;
            if (hsum >= {1'b0, H_ACTIVE}) begin
               hacc_q <= hsum[15:0] - H_ACTIVE;
               hlvl_q <= hlvl_q + 8'd1;
            end else begin
               hacc_q <= hsum[15:0];
            end
         end
      end
   end
   // ----------------------------------------
   // auto-scroll
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         scroll_sel_q <= `VTP_SEL_FIRST;
         fcnt_q       <= 8'h00;
      end else if (!cfg_q[`VTP_CFG_ASCRL]) begin
         scroll_sel_q <= ctl_q[`VTP_CTL_SEL]; // hold current pattern
         fcnt_q       <= 8'h00;
      end else if (take & eof) begin
         if (fcnt_q + 8'd1 >= ftime_q) begin
            fcnt_q <= 8'h00;
            if (scroll_sel_q >= `VTP_SEL_LAST || scroll_sel_q < `VTP_SEL_FIRST) begin
               scroll_sel_q <= `VTP_SEL_FIRST;
            end else begin
               scroll_sel_q <= scroll_sel_q + 4'h1;
            end
         end else begin
            fcnt_q <= fcnt_q + 8'd1;
         end
      end
   end
   assign act_sel = cfg_q[`VTP_CFG_ASCRL] ? scroll_sel_q : ctl_q[`VTP_CTL_SEL];
   // ----------------------------------------
   // pattern colour
   // ----------------------------------------
   reg [23:0] base, bar, band, gen;
   always @* begin
      case (hlvl_q[7:5])
         3'h0:    bar = `VTP_WHITE;
         3'h1:    bar = `VTP_YELLOW;
         3'h2:    bar = `VTP_CYAN;
         3'h3:    bar = `VTP_GREEN;
         3'h4:    bar = `VTP_MAGENTA;
         3'h5:    bar = `VTP_RED;
         3'h6:    bar = `VTP_BLUE;
         default: bar = `VTP_BLACK;
      endcase
      case ({ctl_q[`VTP_CTL_VREV], hlvl_q[7:6]})
         3'h0:    band = `VTP_YELLOW;
         3'h1:    band = `VTP_CYAN;
         3'h2:    band = `VTP_BLUE;
         3'h4:    band = `VTP_BLUE;
         3'h5:    band = `VTP_CYAN;
         3'h6:    band = `VTP_YELLOW;
         default: band = `VTP_RED;
      endcase
      case (act_sel)
         4'h1:    base = `VTP_WHITE;
         4'h2:    base = `VTP_BLACK;
         4'h3:    base = `VTP_RED;
         4'h4:    base = `VTP_GREEN;
         4'h5:    base = `VTP_BLUE;
         4'h6:    base = {hlvl_q, hlvl_q, hlvl_q};
         4'h7:    base = {hlvl_q, 8'h00, 8'h00};
         4'h8:    base = {8'h00, hlvl_q, 8'h00};
         4'h9:    base = {8'h00, 8'h00, hlvl_q};
         4'hA:    base = {vlvl_q, vlvl_q, vlvl_q};
         4'hB:    base = {vlvl_q, 8'h00, 8'h00};
         4'hC:    base = {8'h00, vlvl_q, 8'h00};
         4'hD:    base = {8'h00, 8'h00, vlvl_q};
         `VTP_SEL_CUSTOM: base = {red_q, grn_q, blu_q};
         default: base = `VTP_BLACK; // reserved codes give black
      endcase
      if (ctl_q[`VTP_CTL_COMP]) begin
         gen = band;
      end else if (ctl_q[`VTP_CTL_BARS]) begin
         gen = bar;
      end else begin
         gen = base;
      end
      if (cfg_q[`VTP_CFG_INV]) begin
         gen = ~gen;
      end
      if (cfg_q[`VTP_CFG_18B]) begin
         gen = gen & `VTP_MASK18;
      end
   end
   // ----------------------------------------
   // output path
   // ----------------------------------------
   // generator only replaces data; pixel timing still comes from the input
   // stream, so a full fifo stalls the source rather than dropping pixels
   wire [23:0] mux_data;
   assign mux_data = ctl_q[`VTP_CTL_EN] ? gen : vid_data;
   vtp_fifo #(
      .W  (24),
      .D  (FIFO_D),
      .AW (FIFO_AW)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (vid_valid),
      .in_ready  (vid_ready),
      .in_data   (mux_data),
      .out_valid (pix_valid),
      .out_ready (pix_ready),
      .out_data  (pix_data),
      .level     (fifo_level)
   );
endmodule

// *** sim/vtp_monitor.sv ***
// port-level assertion checker for the video test pattern block
`timescale 1ns/1ps
`include "vtp_map.vh"
module vtp_monitor (
   input wire        aclk,
   input wire        aresetn,
   input wire [11:0] s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0]  s_axi_wstrb,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        vid_valid,
   input wire        vid_ready,
   input wire        pix_valid,
   input wire        pix_ready,
   input wire [23:0] pix_data,
   input wire        loopthrough_tx_powerdown
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_pwdn_reset: assert property ($rose(aresetn) |-> !loopthrough_tx_powerdown)
      else $error("powerdown not clear after reset");
   a_pwdn_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && s_axi_awaddr[9:2] == `VTP_IDX_TXPWR && s_axi_wstrb[0]
      |-> ##2 loopthrough_tx_powerdown == $past(s_axi_wdata[0], 2))
      else $error("powerdown bit does not follow write");
   // address and data are held one cycle, then stored and answered together
   a_bresp_after: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_rdata_after: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_pix_hold: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
      else $error("pixel dropped or changed while stalled");
   a_fifo_full: assert property (!vid_ready |-> pix_valid)
      else $error("input refused with empty buffer");
   a_pix_follow: assert property (vid_valid && vid_ready |=> pix_valid)
      else $error("accepted pixel not offered");
endmodule

bind vtp_top vtp_monitor i_vtp_monitor (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .vid_valid(vid_valid),
   .vid_ready(vid_ready), .pix_valid(pix_valid), .pix_ready(pix_ready),
   .pix_data(pix_data), .loopthrough_tx_powerdown(loopthrough_tx_powerdown));

// *** sim/testbench.sv ***
// self-checking bench for the video test pattern block
`timescale 1ns/1ps
`include "vtp_map.vh"
module testbench;
   // ----------------------------------------
   // stimulus and dut
   // ----------------------------------------
   localparam H = 256;
   localparam V = 4;
   reg         aclk = 1'b0;
   reg         aresetn = 1'b0;
   reg  [11:0] awaddr = 12'h000;
   reg         awvalid = 1'b0;
   reg  [31:0] wdata = 32'h00000000;
   reg  [3:0]  wstrb = 4'h0;
   reg         wvalid = 1'b0;
   reg         bready = 1'b0;
   reg  [11:0] araddr = 12'h000;
   reg         arvalid = 1'b0;
   reg         rready = 1'b0;
   reg         vid_valid = 1'b0;
   reg  [23:0] vid_data = 24'h000000;
   reg         pix_ready = 1'b0;
   wire        awready, wready, bvalid, arready, rvalid, vid_ready, pix_valid, pwdn;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [23:0] pix_data;
   integer     n_errors = 0;
   integer     compares = 0;
   integer     cnt = 0;
   reg  [1:0]  rs;
   reg  [31:0] rd;

   vtp_top #(.H_ACTIVE(16'd256), .V_ACTIVE(16'd4)) i_vtp_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .vid_valid(vid_valid), .vid_ready(vid_ready), .vid_data(vid_data),
      .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
      .loopthrough_tx_powerdown(pwdn));

   initial begin
      forever #12.5 aclk = ~aclk;
   end

   // ----------------------------------------
   // common tasks
   // ----------------------------------------
   task end_sim;
      begin
         if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask

   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         compares = compares + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("unexpected %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   task chk_px(input [23:0] e, input [23:0] g);
      chk("pixel", {8'h00, e}, {8'h00, g});
   endtask

   // a wait that ran out ends the run at once
   task guard(input ok);
      begin
         if (ok !== 1'b1) begin
            chk("wait", 32'h1, 32'h0);
            end_sim;
         end
      end
   endtask

   task do_reset;
      begin
         aresetn <= 1'b0;
         repeat (4) @(posedge aclk);
         aresetn <= 1'b1;
         cnt = 0;
      end
   endtask

   task wr(input [7:0] idx, input [7:0] d, input [3:0] st);
      integer i;
      begin
         awaddr <= {2'b00, idx, 2'b00};
         wdata <= {24'h000000, d};
         wstrb <= st;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         i = 0;
         do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            i = i + 1;
         end while (!bvalid && i < 200);
         guard(bvalid);
         rs = bresp;
         bready <= 1'b0;
      end
   endtask

   task rchk(input [7:0] idx, input [7:0] e, input [1:0] er);
      integer i;
      begin
         araddr <= {2'b00, idx, 2'b00};
         arvalid <= 1'b1;
         rready <= 1'b1;
         i = 0;
         do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            i = i + 1;
         end while (!rvalid && i < 200);
         guard(rvalid);
         rd = rdata;
         rs = rresp;
         rready <= 1'b0;
         chk("register", {24'h000000, e}, rd);
         chk("read resp", {30'h0, er}, {30'h0, rs});
      end
   endtask

   // expected pixel, from control, config and raster position
   function [23:0] ex(input [7:0] c, input [7:0] f, input integer x, input integer y);
      integer t;
      reg [7:0] l;
      reg [23:0] p;
      begin
         t = (c[7:4] < 4'hA) ? x * 256 / H : y * 256 / V;
         l = t[7:0];
         if (c[3]) begin
            case (x * 4 / H)
               0: p = c[1] ? `VTP_BLUE : `VTP_YELLOW;
               1: p = `VTP_CYAN;
               2: p = c[1] ? `VTP_YELLOW : `VTP_BLUE;
               default: p = `VTP_RED;
            endcase
         end else if (c[2]) begin
            case (x * 8 / H)
               0: p = `VTP_WHITE;
               1: p = `VTP_YELLOW;
               2: p = `VTP_CYAN;
               3: p = `VTP_GREEN;
               4: p = `VTP_MAGENTA;
               5: p = `VTP_RED;
               6: p = `VTP_BLUE;
               default: p = `VTP_BLACK;
            endcase
         end else begin
            case (c[7:4])
               4'h1: p = `VTP_WHITE;
               4'h3: p = `VTP_RED;
               4'h4: p = `VTP_GREEN;
               4'h5: p = `VTP_BLUE;
               4'h6, 4'hA: p = {l, l, l};
               4'h7, 4'hB: p = {l, 16'h0000};
               4'h8, 4'hC: p = {8'h00, l, 8'h00};
               4'h9, 4'hD: p = {16'h0000, l};
               4'hE: p = 24'h123456;
               default: p = `VTP_BLACK;
            endcase
         end
         p = f[1] ? ~p : p;
         ex = f[4] ? (p & `VTP_MASK18) : p;
      end
   endfunction

   // one pixel in, one out, judged against its raster position
   task pixels(input [7:0] c, input [7:0] f, input integer n);
      integer k, i;
      begin
         pix_ready <= 1'b1;
         for (k = 0; k < n; k = k + 1) begin
            vid_valid <= 1'b1;
            vid_data <= 24'hA5C3E1;
            i = 0;
            do begin
               @(posedge aclk);
               i = i + 1;
            end while (!vid_ready && i < 50);
            guard(vid_ready);
            vid_valid <= 1'b0;
            i = 0;
            do begin
               @(posedge aclk);
               i = i + 1;
            end while (!pix_valid && i < 50);
            guard(pix_valid);
            chk_px(ex(c, f, cnt % H, (cnt / H) % V), pix_data);
            cnt = cnt + 1;
         end
      end
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_regs;
      begin
         rchk(`VTP_IDX_TXPWR, 8'h00, `VTP_RESP_OKAY);
         rchk(`VTP_IDX_CTL, 8'h10, `VTP_RESP_OKAY);
         rchk(`VTP_IDX_CFG, 8'h00, `VTP_RESP_OKAY);
         rchk(`VTP_IDX_FTIME, 8'h01, `VTP_RESP_OKAY);
         rchk(8'h40, 8'h00, `VTP_RESP_SLVERR);
         wr(8'h40, 8'hFF, 4'hF);
         chk("write resp", `VTP_RESP_SLVERR, rs);
         wr(`VTP_IDX_CTL, 8'hF1, 4'h0);
         rchk(`VTP_IDX_CTL, 8'h10, `VTP_RESP_OKAY);
         wr(`VTP_IDX_CFG, 8'hFF, 4'hF);
         rchk(`VTP_IDX_CFG, `VTP_CFG_MASK, `VTP_RESP_OKAY);
         wr(`VTP_IDX_TXPWR, 8'h01, 4'hF);
         chk("powerdown", 32'h1, {31'h0, pwdn});
         rchk(`VTP_IDX_TXPWR, 8'h01, `VTP_RESP_OKAY);
         wr(`VTP_IDX_TXPWR, 8'h00, 4'hF);
         chk("powerdown", 32'h0, {31'h0, pwdn});
      end
   endtask

   // generator off: pixels pass, the buffer fills to 8 and drains in order
   task t_fifo;
      integer i, n, k;
      begin
         pix_ready <= 1'b0;
         vid_valid <= 1'b1;
         vid_data <= 24'h000000;
         n = 0;
         for (i = 0; i < 12; i = i + 1) begin
            @(posedge aclk);
            if (vid_ready) begin
               n = n + 1;
               vid_data <= n;
            end
         end
         vid_valid <= 1'b0;
         chk("fifo level", 32'd8, n);
         pix_ready <= 1'b1;
         k = 0;
         for (i = 0; i < 20 && k < 8; i = i + 1) begin
            @(posedge aclk);
            if (pix_valid) begin
               chk_px(k, pix_data);
               k = k + 1;
            end
         end
         chk("drained", 32'd8, k);
      end
   endtask

   task t_codes;
      integer s, v;
      begin
         do_reset;
         wr(`VTP_IDX_TXPWR, 8'h01, 4'hF);
         wr(`VTP_IDX_RED, 8'h12, 4'hF);
         wr(`VTP_IDX_GRN, 8'h34, 4'hF);
         wr(`VTP_IDX_BLU, 8'h56, 4'hF);
         for (s = 0; s < 16; s = s + 1) begin
            for (v = 0; v < 2; v = v + 1) begin
               wr(`VTP_IDX_CTL, {s[3:0], 4'h1}, 4'hF);
               wr(`VTP_IDX_CFG, {6'h00, v[0], 1'b0}, 4'hF);
               pixels({s[3:0], 4'h1}, {6'h00, v[0], 1'b0}, 20);
            end
         end
      end
   endtask

   task t_prio;
      begin
         do_reset;
         wr(`VTP_IDX_TXPWR, 8'h01, 4'hF);
         wr(`VTP_IDX_CTL, 8'h1D, 4'hF);
         pixels(8'h1D, 8'h00, 256);
         wr(`VTP_IDX_CTL, 8'h1B, 4'hF);
         pixels(8'h1B, 8'h00, 256);
         wr(`VTP_IDX_CTL, 8'h25, 4'hF);
         pixels(8'h25, 8'h00, 256);
         wr(`VTP_IDX_CFG, 8'h12, 4'hF);
         pixels(8'h25, 8'h12, 64);
      end
   endtask

   task t_scroll;
      begin
         do_reset;
         wr(`VTP_IDX_TXPWR, 8'h01, 4'hF);
         wr(`VTP_IDX_CTL, 8'h11, 4'hF);
         wr(`VTP_IDX_CFG, 8'h01, 4'hF);
         wr(`VTP_IDX_CTL, 8'h51, 4'hF);
         rchk(`VTP_IDX_STAT, 8'h11, `VTP_RESP_OKAY);
         pixels(8'h11, 8'h01, H * V);
         rchk(`VTP_IDX_STAT, 8'h12, `VTP_RESP_OKAY);
      end
   endtask

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_fifo;
      t_codes;
      t_prio;
      t_scroll;
      end_sim;
   end
endmodule
